// >>> src/mss_pkg.sv
package mss_pkg;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Gesture and indication timing, in milliseconds, and the steady phase count
  // ----------------------------------------------------------------
  localparam int DEBOUNCE_MS = 20;
  localparam int ARM_HOLD_MS = 3000;
  localparam int HOLD_TOL_MS = 250;
  localparam int TIP_MAX_MS = 3000;
  localparam int FACTORY_HOLD_MS = 30000;
  localparam int PHASE_MS = 1000;
  localparam int OFFER_MS = 10000;
  localparam int BOOT_MS = 500;
  localparam int RUN_FLASH_MS = 500;
  localparam int SLOW_HALF_MS = 250;
  localparam int FAST_HALF_MS = 62;
  localparam int STEADY_TARGET = 6;

  // ----------------------------------------------------------------
  // Package name and address defaults
  // ----------------------------------------------------------------
  localparam logic [15:0] PKG_PREFIX = 16'h7078;
  localparam logic [31:0] ENG_ADDR_DEFAULT = 32'h0000_0000;
  localparam logic [6:0] MP_STATION_DEFAULT = 7'h02;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  // Seventeen states need five bits
  typedef enum logic [4:0] {
    S_BOOT, S_SCAN, S_OFFER, S_UPDATE, S_UPD_ERASE, S_UPD_OK, S_UPD_FAIL,
    S_IDLE, S_HOLD, S_ARMED, S_TIP, S_ORESET, S_FPHASE, S_FREL, S_WIPE,
    S_RUNFLASH, S_FDONE
  } mss_state_t;

endpackage : mss_pkg

// >>> src/mss_sw_if.sv
`timescale 1ns/100ps
// Raw and filtered mode-switch contacts with the shared millisecond tick
interface mss_sw_if;
  logic tick;
  logic [1:0] raw;
  logic [1:0] clean;
  modport filt (input tick, input raw, output clean);
  modport user (output tick, output raw, input clean);
endinterface : mss_sw_if

// >>> src/mss_debounce.sv
`timescale 1ns/100ps
module mss_debounce #(
  parameter int DEB_MS = mss_pkg::DEBOUNCE_MS
) (
  input wire logic mclk,
  input wire logic rst_n,
  mss_sw_if.filt sw
);

  // ----------------------------------------------------------------
  // Contact filter
  // ----------------------------------------------------------------
  // A contact must stay put for DEB_MS ticks; bounce shorter than that
  // never reaches the sequencer, which keeps gesture timing honest
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_filt
      logic [15:0] cnt_reg;
      logic clean_reg;
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          cnt_reg <= 16'h0000;
          clean_reg <= 1'b0;
        end
        else if (sw.raw[g] == clean_reg)
          cnt_reg <= 16'h0000;
        else if (sw.tick)
        begin
          if (cnt_reg >= 16'(DEB_MS - 1))
          begin
            clean_reg <= sw.raw[g];
            cnt_reg <= 16'h0000;
          end
          else
            cnt_reg <= cnt_reg + 16'h0001;
        end
      end
      assign sw.clean[g] = clean_reg;
    end
  endgenerate

endmodule : mss_debounce

// >>> src/mss_top.sv
`timescale 1ns/100ps
module mss_top #(
  parameter int TICK_CYCLES = mss_pkg::TICK_CYCLES,
  parameter int ARM_MS = mss_pkg::ARM_HOLD_MS,
  parameter int TOL_MS = mss_pkg::HOLD_TOL_MS,
  parameter int TIP_MS = mss_pkg::TIP_MAX_MS,
  parameter int FACT_MS = mss_pkg::FACTORY_HOLD_MS,
  parameter int PHASE_LEN_MS = mss_pkg::PHASE_MS,
  parameter int OFFER_LEN_MS = mss_pkg::OFFER_MS,
  parameter int BOOT_LEN_MS = mss_pkg::BOOT_MS,
  parameter logic [47:0] PKG_ID = 48'h3030_3030_3031 // Arbitrary value
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic sw_run,
  input wire logic sw_mem_clear,
  input wire logic card_present,
  input wire logic card_write_protect,
  output logic scan_start,
  input wire logic scan_done,
  input wire logic pkg_found,
  input wire logic [63:0] pkg_name,
  input wire logic [15:0] pkg_version,
  input wire logic [15:0] installed_version,
  input wire logic cmd_factory,
  output logic upd_start,
  input wire logic upd_done,
  input wire logic upd_error,
  output logic erase_start,
  output logic erase_factory,
  input wire logic erase_done,
  input wire logic eng_addr_set,
  input wire logic [31:0] eng_addr_in,
  output logic [31:0] eng_addr,
  output logic [6:0] mp_station_addr,
  output logic power_lamp,
  output logic stop_lamp,
  output logic fault_lamp,
  output logic force_lamp,
  output logic card_lamp,
  output logic run_lamp
);

  // ----------------------------------------------------------------
  // Reset release and time base
  // ----------------------------------------------------------------
  logic rst_s1_reg;
  logic rst_n;
  logic tick_reg;
  logic [31:0] tick_cnt_reg;
  logic slow_reg;
  logic fast_reg;
  logic [15:0] slow_cnt_reg;
  logic [15:0] fast_cnt_reg;

  // Release is synchronised so every flop leaves reset on the same edge
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // Millisecond tick
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end
    else if (tick_cnt_reg == 32'(TICK_CYCLES - 1))
    begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      tick_reg <= 1'b0;
    end
  end

  // Slow and fast blink phases, free running so lamps stay in step
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slow_cnt_reg <= 16'h0000;
      fast_cnt_reg <= 16'h0000;
      slow_reg <= 1'b0;
      fast_reg <= 1'b0;
    end
    else if (tick_reg)
    begin
      slow_cnt_reg <= slow_cnt_reg + 16'h0001;
      fast_cnt_reg <= fast_cnt_reg + 16'h0001;
      if (slow_cnt_reg == 16'(mss_pkg::SLOW_HALF_MS - 1))
      begin
        slow_cnt_reg <= 16'h0000;
        slow_reg <= !slow_reg;
      end
      if (fast_cnt_reg == 16'(mss_pkg::FAST_HALF_MS - 1))
      begin
        fast_cnt_reg <= 16'h0000;
        fast_reg <= !fast_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Switch filtering
  // ----------------------------------------------------------------
  mss_sw_if sw ();
  logic run_c;
  logic mclr_c;
  logic mclr_q_reg;
  logic mclr_rise;

  assign sw.tick = tick_reg;
  assign sw.raw = {sw_mem_clear, sw_run};
  assign run_c = sw.clean[0];
  assign mclr_c = sw.clean[1];
  assign mclr_rise = mclr_c && !mclr_q_reg;

  mss_debounce #(.DEB_MS(mss_pkg::DEBOUNCE_MS)) u_deb (
    .mclk(mclk),
    .rst_n(rst_n),
    .sw(sw.filt)
  );

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      mclr_q_reg <= 1'b0;
    else
      mclr_q_reg <= mclr_c;
  end

  // ----------------------------------------------------------------
  // Package check
  // ----------------------------------------------------------------
  function automatic logic is_digit(input logic [7:0] c);
    is_digit = (c >= 8'h30) && (c <= 8'h39);
  endfunction : is_digit

  function automatic logic name_ok(input logic [63:0] n, input logic [47:0] id);
    logic ok;
    ok = (n[63:48] == mss_pkg::PKG_PREFIX) && (n[47:0] == id);
    for (int i = 0; i < 6; i++)
      ok = ok && is_digit(n[i*8 +: 8]);
    name_ok = ok;
  endfunction : name_ok

  logic pkg_newer;
  // Card write protect is never consulted; the card is treated writable
  logic unused_wp;
  assign unused_wp = card_write_protect;
  assign pkg_newer = pkg_found && name_ok(pkg_name, PKG_ID)
    && (pkg_version != installed_version);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  mss_pkg::mss_state_t state_reg;
  mss_pkg::mss_state_t state_next;
  logic [15:0] tmr_reg;
  logic phase_reg;
  logic [3:0] steady_cnt_reg;
  logic fact_ok_reg;
  logic phase_end;

  assign phase_end = (state_reg == mss_pkg::S_FPHASE) && tick_reg
    && (tmr_reg == 16'(PHASE_LEN_MS - 1));

  // Next state from switch gestures and engine answers
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      mss_pkg::S_BOOT:
        if (tmr_reg >= 16'(BOOT_LEN_MS))
          state_next = (!run_c && !mclr_c && card_present) ? mss_pkg::S_SCAN
            : mss_pkg::S_IDLE;
      mss_pkg::S_SCAN:
        if (scan_done)
          state_next = pkg_newer ? mss_pkg::S_OFFER : mss_pkg::S_IDLE;
      mss_pkg::S_OFFER:
        if (mclr_rise)
          state_next = mss_pkg::S_UPDATE;
        else if (tmr_reg >= 16'(OFFER_LEN_MS))
          state_next = mss_pkg::S_IDLE;
      mss_pkg::S_UPDATE:
        if (upd_done)
          state_next = upd_error ? mss_pkg::S_UPD_FAIL : mss_pkg::S_UPD_ERASE;
      mss_pkg::S_UPD_ERASE:
        if (erase_done)
          state_next = mss_pkg::S_UPD_OK;
      mss_pkg::S_UPD_OK, mss_pkg::S_UPD_FAIL, mss_pkg::S_FDONE:
        state_next = state_reg;
      mss_pkg::S_IDLE:
        if (cmd_factory && !run_c)
          state_next = mss_pkg::S_WIPE;
        // Only a fresh press starts a hold; a switch still held after a quick
        // erase must not be counted as a new arming hold
        else if (mclr_rise && !run_c)
          state_next = mss_pkg::S_HOLD;
      mss_pkg::S_HOLD:
        if (!mclr_c)
          state_next = (tmr_reg >= 16'(ARM_MS - TOL_MS)) ? mss_pkg::S_ARMED
            : mss_pkg::S_IDLE;
        else if (tmr_reg >= 16'(FACT_MS))
          state_next = mss_pkg::S_FPHASE;
      mss_pkg::S_ARMED:
        if (run_c)
          state_next = mss_pkg::S_IDLE;
        else if (mclr_rise)
          state_next = mss_pkg::S_TIP;
      mss_pkg::S_TIP:
        if (!mclr_c)
          state_next = (tmr_reg < 16'(TIP_MS)) ? mss_pkg::S_ORESET
            : mss_pkg::S_ARMED;
      mss_pkg::S_ORESET:
        if (erase_done)
          state_next = mss_pkg::S_IDLE;
      mss_pkg::S_FPHASE:
        if (!mclr_c)
          state_next = mss_pkg::S_FREL;
      mss_pkg::S_FREL:
        if (run_c)
          state_next = mss_pkg::S_IDLE;
        else if (mclr_rise)
          state_next = fact_ok_reg ? mss_pkg::S_WIPE : mss_pkg::S_ORESET;
      mss_pkg::S_WIPE:
        if (erase_done)
          state_next = mss_pkg::S_RUNFLASH;
      mss_pkg::S_RUNFLASH:
        if (tmr_reg >= 16'(mss_pkg::RUN_FLASH_MS))
          state_next = mss_pkg::S_FDONE;
      default:
        state_next = mss_pkg::S_IDLE;
    endcase
  end

  // State and state timer; the timer restarts on every state change
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= mss_pkg::S_BOOT;
      tmr_reg <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      if (state_next != state_reg || phase_end)
        tmr_reg <= 16'h0000;
      else if (tick_reg && tmr_reg != 16'hFFFF)
        tmr_reg <= tmr_reg + 16'h0001;
    end
  end

  // Factory phase counting: flash phase first, steady phases counted
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_reg <= 1'b0;
      steady_cnt_reg <= 4'h0;
      fact_ok_reg <= 1'b0;
    end
    else if (state_reg != mss_pkg::S_FPHASE && state_next == mss_pkg::S_FPHASE)
    begin
      phase_reg <= 1'b0;
      steady_cnt_reg <= 4'h0;
      fact_ok_reg <= 1'b0; // Verdict of an earlier gesture never carries over
    end
    else if (phase_end)
    begin
      phase_reg <= !phase_reg;
      if (!phase_reg && steady_cnt_reg != 4'hF)
        steady_cnt_reg <= steady_cnt_reg + 4'h1;
    end
    else if (state_reg == mss_pkg::S_FPHASE && state_next == mss_pkg::S_FREL)
      // Only a release during or just after the sixth steady phase counts
      fact_ok_reg <= (steady_cnt_reg == 4'(mss_pkg::STEADY_TARGET));
  end

  // ----------------------------------------------------------------
  // Engine requests and addresses
  // ----------------------------------------------------------------
  logic entering;
  assign entering = state_next != state_reg;

  // One-cycle starts on state entry
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scan_start <= 1'b0;
      upd_start <= 1'b0;
      erase_start <= 1'b0;
      erase_factory <= 1'b0;
    end
    else
    begin
      scan_start <= entering && state_next == mss_pkg::S_SCAN;
      upd_start <= entering && state_next == mss_pkg::S_UPDATE;
      erase_start <= entering && (state_next == mss_pkg::S_ORESET
        || state_next == mss_pkg::S_UPD_ERASE || state_next == mss_pkg::S_WIPE);
      if (entering && state_next == mss_pkg::S_WIPE)
        erase_factory <= 1'b1;
      else if (entering && (state_next == mss_pkg::S_ORESET
        || state_next == mss_pkg::S_UPD_ERASE))
        erase_factory <= 1'b0;
    end
  end

  // Overall reset leaves the address alone; only factory reset and nrst restore the defaults
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eng_addr <= mss_pkg::ENG_ADDR_DEFAULT;
      mp_station_addr <= mss_pkg::MP_STATION_DEFAULT;
    end
    else if (state_reg == mss_pkg::S_WIPE && erase_done)
    begin
      eng_addr <= mss_pkg::ENG_ADDR_DEFAULT;
      mp_station_addr <= mss_pkg::MP_STATION_DEFAULT;
    end
    else if (eng_addr_set)
      eng_addr <= eng_addr_in;
  end

  // ----------------------------------------------------------------
  // Lamps
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_lamp <= 1'b0;
      {stop_lamp, fault_lamp, force_lamp, card_lamp, run_lamp} <= 5'h00;
    end
    else
    begin
      power_lamp <= 1'b1;
      {stop_lamp, fault_lamp, force_lamp, card_lamp, run_lamp} <= 5'h00;
      case (state_reg)
        mss_pkg::S_IDLE:
        begin
          stop_lamp <= !run_c;
          run_lamp <= run_c;
        end
        mss_pkg::S_HOLD:
          stop_lamp <= (tmr_reg >= 16'(ARM_MS - TOL_MS)) ? 1'b1 : slow_reg;
        mss_pkg::S_ARMED, mss_pkg::S_TIP, mss_pkg::S_FREL:
          stop_lamp <= 1'b1;
        mss_pkg::S_ORESET, mss_pkg::S_UPD_ERASE, mss_pkg::S_WIPE:
          stop_lamp <= slow_reg;
        mss_pkg::S_FPHASE:
          stop_lamp <= phase_reg ? 1'b1 : fast_reg;
        mss_pkg::S_OFFER:
        begin
          fault_lamp <= slow_reg;
          force_lamp <= !slow_reg;
        end
        mss_pkg::S_UPDATE:
        begin
          fault_lamp <= slow_reg;
          force_lamp <= !slow_reg;
          card_lamp <= 1'b1;
        end
        mss_pkg::S_UPD_OK, mss_pkg::S_FDONE:
          {stop_lamp, fault_lamp, force_lamp, card_lamp} <= 4'hF;
        mss_pkg::S_UPD_FAIL:
        begin
          power_lamp <= fast_reg;
          {stop_lamp, fault_lamp, force_lamp, card_lamp} <= {4{fast_reg}};
        end
        mss_pkg::S_RUNFLASH:
          run_lamp <= 1'b1;
        default:
          stop_lamp <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_arm_lamp_on: assert property ((state_reg == mss_pkg::S_HOLD
    && tmr_reg >= 16'(ARM_MS - TOL_MS)) |=> stop_lamp)
    else $error("stop lamp not steady after arming hold");
  a_tip_starts_reset: assert property ((state_reg == mss_pkg::S_TIP && !mclr_c
    && tmr_reg < 16'(TIP_MS)) |=> erase_start && !erase_factory)
    else $error("short tip did not start overall reset");
  a_reset_done_lamp: assert property ((state_reg == mss_pkg::S_ORESET && erase_done
    && !run_c) |=> (state_reg == mss_pkg::S_IDLE) ##1 (stop_lamp || run_c))
    else $error("stop lamp not steady after overall reset");
  a_equal_no_offer: assert property ((state_reg == mss_pkg::S_SCAN && scan_done
    && pkg_version == installed_version) |=> state_reg != mss_pkg::S_OFFER)
    else $error("equal version was offered");
  a_offer_window: assert property ((state_reg == mss_pkg::S_OFFER)
    |-> tmr_reg <= 16'(OFFER_LEN_MS))
    else $error("offer outlived its window");
  a_update_lamps: assert property ((state_reg == mss_pkg::S_UPDATE)[*2]
    |-> card_lamp && (fault_lamp != force_lamp))
    else $error("update lamps wrong");
  a_update_erases: assert property ((state_reg == mss_pkg::S_UPDATE && upd_done
    && !upd_error) |=> erase_start && !erase_factory)
    else $error("update not followed by overall reset");
  a_factory_miss: assert property ((state_reg == mss_pkg::S_FREL && mclr_rise
    && !fact_ok_reg && !run_c) |=> erase_start && !erase_factory)
    else $error("missed factory gesture not an overall reset");
  a_factory_addr: assert property ((state_reg == mss_pkg::S_WIPE && erase_done)
    |=> eng_addr == 32'h0000_0000 && mp_station_addr == 7'h02 ##1 run_lamp)
    else $error("factory reset addresses or run lamp wrong");
  a_fail_fast: assert property ((state_reg == mss_pkg::S_UPD_FAIL)[*2]
    |-> stop_lamp == fast_reg || $changed(fast_reg))
    else $error("failure lamps not fast blinking");

  c_overall_reset: cover property (state_reg == mss_pkg::S_TIP ##1
    state_reg == mss_pkg::S_ORESET);
  c_update_ok: cover property (state_reg == mss_pkg::S_UPD_OK);
  c_factory_done: cover property (state_reg == mss_pkg::S_FDONE);
  c_offer_timeout: cover property (state_reg == mss_pkg::S_OFFER ##1
    state_reg == mss_pkg::S_IDLE);

endmodule : mss_top

// >>> tb/mss_card_model.sv
`timescale 1ns/100ps
// ---
// Card and memory back end seen from the sequencer
// ---
module mss_card_model (
  input wire logic mclk,
  input wire logic slow,
  input wire logic fail,
  input wire logic scan_start,
  input wire logic upd_start,
  input wire logic erase_start,
  output logic scan_done,
  output logic upd_done,
  output logic upd_error,
  output logic erase_done
);
  initial
  begin
    scan_done = 1'b0;
    upd_done = 1'b0;
    upd_error = 1'b1;
    erase_done = 1'b0;
  end

  // Directory search answers quickly; the file contents are held by the bench
  always @(posedge mclk)
    if (scan_start)
    begin
      repeat (2) @(posedge mclk);
      scan_done <= 1'b1;
      @(posedge mclk);
      scan_done <= 1'b0;
    end

  // Transfer is slow so the busy lamps can be seen; error is junk off its strobe
  always @(posedge mclk)
    if (upd_start)
    begin
      repeat (400) @(posedge mclk);
      upd_done <= 1'b1;
      upd_error <= fail;
      @(posedge mclk);
      upd_done <= 1'b0;
      upd_error <= ~fail;
    end

  // Erase length is chosen by the bench: long enough to see a slow blink when slow is set, else 4 cycles
  always @(posedge mclk)
    if (erase_start)
    begin
      repeat (slow ? 3000 : 4) @(posedge mclk);
      erase_done <= 1'b1;
      @(posedge mclk);
      erase_done <= 1'b0;
    end
endmodule : mss_card_model

// >>> tb/mode_switch_reset_sequencer_bench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module mode_switch_reset_sequencer_bench;
  // ---
  // Stimulus, monitors and design
  // ---
  typedef struct packed {logic card, newer, name_ok, err, tip, wp;} mss_row_t;
  localparam logic [47:0] ID = 48'h3030_3030_3031; // Arbitrary value
  // Scaled timings keep the run short; debounce stays at its full 20 ms
  localparam int TK = 10, T_ARM = 30, T_TOL = 5, T_TIP = 30, T_FACT = 300;
  localparam int T_PH = 10, T_OFF = 100, T_BOOT = 5;
  logic mclk = 0, nrst = 0, sw_mem_clear = 0, card_present = 0, wp = 0, sw_run = 0;
  logic cmd_factory = 0, eng_addr_set = 0, slow = 0, fail = 0, pkg_found = 0;
  logic [31:0] eng_addr_in = 32'h0;
  logic [63:0] pkg_name = 64'h0;
  logic [15:0] pkg_version = 16'h0;
  logic [15:0] inst_ver = 16'h0101;
  logic scan_start, scan_done, upd_start, upd_done, upd_error;
  logic erase_start, erase_factory, erase_done, fac_q;
  logic power_lamp, stop_lamp, fault_lamp, force_lamp, card_lamp, run_lamp;
  logic [31:0] eng_addr;
  logic [6:0] mp_station_addr;
  logic [4:0] lamp5, lamp_q;
  int err_count = 0, n_tests = 0, cyc = 0, sc_n = 0, up_n = 0, er_n = 0, tg = 0;
  int s0, u0, e0, t0;
  logic offer;
  mss_row_t r;
  mss_row_t rows [6] = '{6'b111011, 6'b111110, 6'b101010, 6'b110010, 6'b111000,
    6'b011010};

  assign lamp5 = {power_lamp, stop_lamp, fault_lamp, force_lamp, card_lamp};

  always #4 mclk = ~mclk;

  // Event counters keep the checks independent of exact pulse cycles
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    lamp_q <= lamp5;
    if (lamp5 !== lamp_q) tg <= tg + 1;
    if (scan_start) sc_n <= sc_n + 1;
    if (upd_start) up_n <= up_n + 1;
    if (erase_start) er_n <= er_n + 1;
    if (erase_start) fac_q <= erase_factory;
    if (cyc == 50000)
    begin
      err_count++;
      end_sim();
    end
  end

  mss_top #(.TICK_CYCLES(TK), .ARM_MS(T_ARM), .TOL_MS(T_TOL), .TIP_MS(T_TIP),
    .FACT_MS(T_FACT), .PHASE_LEN_MS(T_PH), .OFFER_LEN_MS(T_OFF), .BOOT_LEN_MS(T_BOOT),
    .PKG_ID(ID)) i_dut (
    .mclk, .nrst, .sw_run, .sw_mem_clear, .card_present,
    .card_write_protect(wp), .scan_start, .scan_done, .pkg_found, .pkg_name,
    .pkg_version, .installed_version(inst_ver), .cmd_factory, .upd_start,
    .upd_done, .upd_error, .erase_start, .erase_factory, .erase_done,
    .eng_addr_set, .eng_addr_in, .eng_addr, .mp_station_addr, .power_lamp, .stop_lamp,
    .fault_lamp, .force_lamp, .card_lamp, .run_lamp);

  mss_card_model i_card (.mclk, .slow, .fail, .scan_start, .upd_start,
    .erase_start, .scan_done, .upd_done, .upd_error, .erase_done);

  // ---
  // Tasks
  // ---
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt

  task automatic boot();
    nrst <= 1'b0;
    wt(8);
    nrst <= 1'b1;
    wt(100);
  endtask : boot

  // Debounce delays press and release alike; presses under 20 ms never register
  task automatic sw(input int hold);
    sw_mem_clear <= 1'b1;
    wt(hold);
    sw_mem_clear <= 1'b0;
  endtask : sw

  // Long hold, release, then a tip; only a release during or just after the sixth steady phase wipes
  task automatic fact(input int hold, input logic exp);
    e0 = er_n;
    sw(hold);
    wt(300);
    sw(250);
    wt(400);
    `CHK(er_n - e0, 1)
    `CHK(fac_q, exp)
  endtask : fact

  task automatic end_sim();
    $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  // ---
  // Sequence
  // ---
  initial
  begin
    @(posedge mclk);
    foreach (rows[i])
    begin
      r = rows[i];
      card_present <= r.card;
      pkg_found <= r.card;
      wp <= r.wp;
      fail <= r.err;
      pkg_version <= r.newer ? 16'h0102 : 16'h0101;
      pkg_name <= {r.name_ok ? mss_pkg::PKG_PREFIX : 16'h7079, ID};
      s0 = sc_n;
      u0 = up_n;
      e0 = er_n;
      offer = r.card & r.newer & r.name_ok;
      boot();
      `CHK(sc_n - s0, int'(r.card))
      `CHK(fault_lamp ^ force_lamp, offer)
      if (offer & r.tip)
      begin
        sw(300);
        `CHK(up_n - u0, 1)
        `CHK(card_lamp & (fault_lamp ^ force_lamp), 1'b1)
        wt(600);
        `CHK(er_n - e0, int'(!r.err))
        t0 = tg;
        wt(1400);
        `CHK(tg == t0, !r.err)
        `CHK(r.err || lamp5 === 5'h1F, 1'b1)
      end
      else
      begin
        wt(1100);
        sw(300);
        wt(300);
        `CHK(up_n - u0, 0)
        `CHK({fault_lamp, force_lamp}, 2'b00)
      end
      $display("card row %0d done", i);
    end
    card_present <= 1'b0;
    nrst <= 1'b0;
    wt(3);
    `CHK({mp_station_addr, eng_addr, lamp5, run_lamp}, {7'h02, 38'h0})
    nrst <= 1'b1;
    wt(100);
    `CHK(power_lamp, 1'b1)
    sw_run <= 1'b1;
    wt(300);
    `CHK({run_lamp, stop_lamp}, 2'b10)
    sw_run <= 1'b0;
    wt(300);
    $display("reset test done");
    eng_addr_in <= 32'h0A00_0001;
    eng_addr_set <= 1'b1;
    wt(1);
    eng_addr_set <= 1'b0;
    `CHK(stop_lamp, 1'b1)
    e0 = er_n;
    sw(400);
    wt(300);
    `CHK({er_n - e0, stop_lamp}, {32'h0, 1'b1})
    slow <= 1'b1;
    sw(250);
    wt(300);
    `CHK({er_n - e0, fac_q}, {32'h1, 1'b0})
    t0 = tg;
    wt(2800);
    `CHK(tg != t0, 1'b1)
    slow <= 1'b0;
    wt(600);
    `CHK({stop_lamp, eng_addr}, {1'b1, 32'h0A00_0001})
    $display("overall reset test done");
    fact(4380, 1'b0);
    fact(4180, 1'b1);
    `CHK(run_lamp, 1'b1)
    `CHK({eng_addr, mp_station_addr}, {32'h0, 7'h02})
    wt(5200);
    `CHK({lamp5, run_lamp}, 6'h3E)
    $display("factory test done");
    boot();
    e0 = er_n;
    cmd_factory <= 1'b1;
    wt(1);
    cmd_factory <= 1'b0;
    wt(20);
    `CHK({er_n - e0, fac_q}, {32'h1, 1'b1})
    $display("command file test done");
    end_sim();
  end
endmodule : mode_switch_reset_sequencer_bench
